/* verilog/gcd_pkg.sv */
// Package: bus addresses, field limits, decoded kinds and carrier structs for the command decoder.
package gcd_pkg;

  // ==========================================================================
  // Bus map
  // ==========================================================================
  localparam logic [11:0] ADDR_CMD_WORD = 12'h000;
  localparam logic [11:0] ADDR_CONTROL = 12'h004;
  localparam logic [11:0] ADDR_STATUS = 12'h008;
  localparam logic [11:0] ADDR_DECODE = 12'h00C;
  localparam logic [11:0] ADDR_OPINFO = 12'h010;
  localparam logic [11:0] ADDR_POINTER = 12'h014;
  localparam logic [11:0] ADDR_MASK = 12'h018;
  localparam logic [11:0] ADDR_MOD_IN = 12'h01C;
  localparam logic [11:0] ADDR_MOD_OUT = 12'h020;
  localparam logic [11:0] ADDR_BYTE_WORD = 12'h024;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int CLK_PER_OP_CYCLE = 2;
  localparam logic [3:0] DOT_COST_SIMPLE = 4'h4;
  localparam logic [3:0] DOT_COST_COND = 4'h6;

  // ==========================================================================
  // Field limits and layouts
  // ==========================================================================
  localparam logic [4:0] PARAM_REG_MAX = 5'h13;
  localparam logic [3:0] PATTERN_MAX = 4'hF;
  localparam int PTR_HIGH_BITS = 8;
  localparam int PTR_LOW_BITS = 12;

  typedef enum logic [1:0] {
    SCREEN_UPPER,
    SCREEN_BASE,
    SCREEN_LOWER,
    SCREEN_WINDOW
  } screen_t;

  typedef enum logic [1:0] {
    BOP_REPLACE,
    BOP_OR,
    BOP_AND,
    BOP_XOR
  } bit_op_t;

  typedef enum logic [5:0] {
    K_UNDEF, K_ORG, K_WPR, K_RPR, K_WPTN, K_RPTN,
    K_DRD, K_DWT, K_DMOD, K_RD, K_WT, K_MOD, K_CLR, K_SCLR, K_CPY, K_MASKED_AREA_COPY,
    K_AMOVE, K_RMOVE, K_ALINE, K_RLINE, K_ARCT, K_RRCT, K_APLL, K_RPLL,
    K_APLG, K_RPLG, K_CRCL, K_ELPS, K_AARC, K_RARC, K_AEARC, K_REARC,
    K_AFRCT, K_RFRCT, K_PAINT, K_DOT, K_PTN, K_AGCPY, K_RGCPY
  } cmd_kind_t;

  typedef struct packed {
    cmd_kind_t kind;
    logic [3:0] fixed_params;
    logic counted;
    logic [1:0] group;
  } decode_t;

  typedef struct packed {
    logic [2:0] area_mode;
    logic [1:0] hue_source_field;
    logic [2:0] logic_op_field;
    logic [3:0] dot_cost;
    logic turn_sense;
    logic bound_tint_flag;
    logic [1:0] bit_op_select;
    logic [4:0] param_reg_index;
    logic [3:0] pattern_start_index;
  } opinfo_t;

  typedef struct packed {
    screen_t screen_select_field;
    logic [3:0] dot_in_word;
    logic [PTR_HIGH_BITS+PTR_LOW_BITS-1:0] address;
  } pointer_t;

  localparam logic [1:0] GRP_REG = 2'h0;
  localparam logic [1:0] GRP_XFER = 2'h1;
  localparam logic [1:0] GRP_DRAW = 2'h2;
  localparam logic [1:0] GRP_NONE = 2'h3;

endpackage : gcd_pkg

/* verilog/gcd_opcode_decode.sv */
// Combinational opcode classifier: kind, parameter count and command fields.
`timescale 1ns/1ps
module gcd_opcode_decode
  import gcd_pkg::*;
(
  input wire logic [15:0] opcode_i,
  output decode_t dec_o,
  output opinfo_t info_o
);

  function automatic decode_t mk(input cmd_kind_t k, input logic [3:0] n, input logic c, input logic [1:0] g);
    decode_t d;
    d.kind = k;
    d.fixed_params = n;
    d.counted = c;
    d.group = g;
    return d;
  endfunction : mk

  logic [7:0] code;
  assign code = opcode_i[15:8];

  always_comb begin
    dec_o = mk(K_UNDEF, 4'h0, 1'b0, GRP_NONE);
    if (opcode_i == 16'h0400) begin
      dec_o = mk(K_ORG, 4'h2, 1'b0, GRP_REG);
    end else if (opcode_i[15:5] == 11'h040) begin
      if (opcode_i[4:0] <= PARAM_REG_MAX) dec_o = mk(K_WPR, 4'h1, 1'b0, GRP_REG);
    end else if (opcode_i[15:5] == 11'h060) begin
      if (opcode_i[4:0] <= PARAM_REG_MAX) dec_o = mk(K_RPR, 4'h0, 1'b0, GRP_REG);
    end else if (opcode_i[15:4] == 12'h180) begin
      dec_o = mk(K_WPTN, 4'h1, 1'b1, GRP_REG);
    end else if (opcode_i[15:4] == 12'h1C0) begin
      dec_o = mk(K_RPTN, 4'h1, 1'b0, GRP_REG);
    end else if (opcode_i == 16'h2400) begin
      dec_o = mk(K_DRD, 4'h2, 1'b0, GRP_XFER);
    end else if (opcode_i == 16'h2800) begin
      dec_o = mk(K_DWT, 4'h2, 1'b0, GRP_XFER);
    end else if (opcode_i[15:2] == 14'h0B00) begin
      dec_o = mk(K_DMOD, 4'h2, 1'b0, GRP_XFER);
    end else if (opcode_i == 16'h4400) begin
      dec_o = mk(K_RD, 4'h0, 1'b0, GRP_XFER);
    end else if (opcode_i == 16'h4800) begin
      dec_o = mk(K_WT, 4'h1, 1'b0, GRP_XFER);
    end else if (opcode_i[15:2] == 14'h1300) begin
      dec_o = mk(K_MOD, 4'h1, 1'b0, GRP_XFER);
    end else if (opcode_i == 16'h5800) begin
      dec_o = mk(K_CLR, 4'h3, 1'b0, GRP_XFER);
    end else if (opcode_i[15:2] == 14'h1700) begin
      dec_o = mk(K_SCLR, 4'h3, 1'b0, GRP_XFER);
    end else if (code[7:4] == 4'h6 && opcode_i[7:0] == 8'h00) begin
      dec_o = mk(K_CPY, 4'h4, 1'b0, GRP_XFER);
    end else if (code[7:4] == 4'h7 && opcode_i[7:2] == 6'h00) begin
      dec_o = mk(K_MASKED_AREA_COPY, 4'h4, 1'b0, GRP_XFER);
    end else if (opcode_i[15] == 1'b1) begin
      if (code == 8'h80) dec_o = mk(K_AMOVE, 4'h2, 1'b0, GRP_DRAW);
      else if (code == 8'h84) dec_o = mk(K_RMOVE, 4'h2, 1'b0, GRP_DRAW);
      else if (code == 8'h88) dec_o = mk(K_ALINE, 4'h2, 1'b0, GRP_DRAW);
      else if (code == 8'h8C) dec_o = mk(K_RLINE, 4'h2, 1'b0, GRP_DRAW);
      else if (code == 8'h90) dec_o = mk(K_ARCT, 4'h2, 1'b0, GRP_DRAW);
      else if (code == 8'h94) dec_o = mk(K_RRCT, 4'h2, 1'b0, GRP_DRAW);
      else if (code == 8'h98) dec_o = mk(K_APLL, 4'h1, 1'b1, GRP_DRAW);
      else if (code == 8'h9C) dec_o = mk(K_RPLL, 4'h1, 1'b1, GRP_DRAW);
      else if (code == 8'hA0) dec_o = mk(K_APLG, 4'h1, 1'b1, GRP_DRAW);
      else if (code == 8'hA4) dec_o = mk(K_RPLG, 4'h1, 1'b1, GRP_DRAW);
      else if (code[7:1] == 7'h54) dec_o = mk(K_CRCL, 4'h1, 1'b0, GRP_DRAW);
      else if (code[7:1] == 7'h56) dec_o = mk(K_ELPS, 4'h3, 1'b0, GRP_DRAW);
      else if (code[7:1] == 7'h58) dec_o = mk(K_AARC, 4'h4, 1'b0, GRP_DRAW);
      else if (code[7:1] == 7'h5A) dec_o = mk(K_RARC, 4'h4, 1'b0, GRP_DRAW);
      else if (code[7:1] == 7'h5C) dec_o = mk(K_AEARC, 4'h6, 1'b0, GRP_DRAW);
      else if (code[7:1] == 7'h5E) dec_o = mk(K_REARC, 4'h6, 1'b0, GRP_DRAW);
      else if (code == 8'hC0) dec_o = mk(K_AFRCT, 4'h2, 1'b0, GRP_DRAW);
      else if (code == 8'hC4) dec_o = mk(K_RFRCT, 4'h2, 1'b0, GRP_DRAW);
      else if (code[7:1] == 7'h64 && opcode_i[4:0] == 5'h00) dec_o = mk(K_PAINT, 4'h0, 1'b0, GRP_DRAW);
      else if (code == 8'hCC) dec_o = mk(K_DOT, 4'h0, 1'b0, GRP_DRAW);
      else if (code[7:4] == 4'hD) dec_o = mk(K_PTN, 4'h1, 1'b0, GRP_DRAW);
      else if (code[7:4] == 4'hE && opcode_i[4:3] == 2'h0) dec_o = mk(K_AGCPY, 4'h4, 1'b0, GRP_DRAW);
      else if (code[7:4] == 4'hF && opcode_i[4:3] == 2'h0) dec_o = mk(K_RGCPY, 4'h4, 1'b0, GRP_DRAW);
    end
  end

  always_comb begin
    info_o.area_mode = opcode_i[7:5];
    info_o.hue_source_field = opcode_i[4:3];
    info_o.logic_op_field = opcode_i[2:0];
    info_o.dot_cost = opcode_i[2] ? DOT_COST_COND : DOT_COST_SIMPLE;
    info_o.turn_sense = opcode_i[8];
    info_o.bound_tint_flag = opcode_i[8];
    info_o.bit_op_select = opcode_i[1:0];
    info_o.param_reg_index = opcode_i[4:0];
    info_o.pattern_start_index = opcode_i[3:0];
  end

endmodule : gcd_opcode_decode

/* verilog/gcd_bit_modify.sv */
// Masked bit-level modify unit for the modifying transfer commands.
`timescale 1ns/1ps
module gcd_bit_modify
  import gcd_pkg::*;
(
  input wire logic [15:0] frame_i,
  input wire logic [15:0] data_i,
  input wire logic [15:0] mask_i,
  input wire logic [1:0] bit_op_select_i,
  output logic [15:0] result_o
);

  logic [15:0] op_res;

  always_comb begin
    case (bit_op_t'(bit_op_select_i))
      BOP_REPLACE: op_res = data_i;
      BOP_OR: op_res = frame_i | data_i;
      BOP_AND: op_res = frame_i & data_i;
      default: op_res = frame_i ^ data_i;
    endcase
    result_o = (op_res & mask_i) | (frame_i & ~mask_i);
  end

endmodule : gcd_bit_modify

/* verilog/gcd_command_decoder.sv */
// Command word decoder with an APB register interface.
//
// Our own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module gcd_command_decoder
  import gcd_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef enum {
    ST_IDLE,
    ST_PARAM,
    ST_COUNT,
    ST_EXEC
  } phase_t;

  typedef struct packed {
    phase_t phase;
    logic [15:0] opcode;
    decode_t dec;
    opinfo_t info;
    logic [15:0] params_left;
    logic [3:0] param_idx;
    logic [15:0] hold_word;
    logic [15:0] first_param;
    logic [15:0] busy_cnt;
    logic op_div;
    logic enable;
    logic byte_mode;
    logic high_pending;
    logic [7:0] high_byte;
    logic undef_seen;
    logic [15:0] cmd_count;
    pointer_t pointer;
    logic [15:0] mask;
    logic [15:0] mod_in;
    logic [15:0] mod_out;
    logic [31:0] rdata;
    logic err;
  } state_t;

  state_t cur_ff;
  state_t nxt_cur;

  decode_t dec_w;
  opinfo_t info_w;
  logic [15:0] mod_res;
  logic [15:0] word_in;

  gcd_opcode_decode u_decode (
    .opcode_i(word_in),
    .dec_o(dec_w),
    .info_o(info_w)
  );

  gcd_bit_modify u_modify (
    .frame_i(cur_ff.mod_in),
    .data_i(cur_ff.first_param),
    .mask_i(cur_ff.mask),
    .bit_op_select_i(cur_ff.info.bit_op_select),
    .result_o(mod_res)
  );

  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic logic [15:0] exec_cycles(input decode_t d, input opinfo_t i);
    logic [15:0] c;
    c = 16'h0008;
    if (d.group == GRP_DRAW) c = {12'h000, i.dot_cost} + 16'h0008;
    else if (d.kind == K_RD) c = 16'h000C;
    else if (d.kind == K_WPR || d.kind == K_RPR) c = 16'h0006;
    return c;
  endfunction : exec_cycles

  logic wr_acc;
  logic rd_acc;
  logic word_valid;
  logic [15:0] busy_lim;

  assign wr_acc = PSEL_I && PENABLE_I && PWRITE_I;
  assign rd_acc = PSEL_I && PENABLE_I && !PWRITE_I;
  assign busy_lim = exec_cycles(cur_ff.dec, cur_ff.info);

  // A command word arrives as one 16-bit write or, in byte mode, two byte writes high first.
  always_comb begin
    word_valid = 1'b0;
    word_in = PWDATA_I[15:0];
    if (wr_acc && PADDR_I == ADDR_CMD_WORD) begin
      if (!cur_ff.byte_mode) begin
        word_valid = 1'b1;
      end else if (cur_ff.high_pending) begin
        word_valid = 1'b1;
        word_in = {cur_ff.high_byte, PWDATA_I[7:0]};
      end
    end
  end

  // Words are held off while executing so the internal command has a fixed length.
  assign PREADY_O = !(PSEL_I && PWRITE_I && PADDR_I == ADDR_CMD_WORD && cur_ff.phase == ST_EXEC);

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.err = 1'b0;
    if (cur_ff.phase == ST_EXEC) begin
      nxt_cur.op_div = ~cur_ff.op_div;
      if (cur_ff.op_div) nxt_cur.busy_cnt = cur_ff.busy_cnt + 16'h0001;
      if (cur_ff.op_div && cur_ff.busy_cnt + 16'h0001 >= busy_lim) nxt_cur.phase = ST_IDLE;
    end
    if (wr_acc && PREADY_O) begin
      if (PADDR_I == ADDR_CMD_WORD) begin
        if (cur_ff.byte_mode) begin
          nxt_cur.high_pending = ~cur_ff.high_pending;
          if (!cur_ff.high_pending) nxt_cur.high_byte = PWDATA_I[7:0];
        end
        if (word_valid && cur_ff.enable) begin
          case (cur_ff.phase)
            ST_IDLE: begin
              nxt_cur.opcode = word_in;
              nxt_cur.dec = dec_w;
              nxt_cur.info = info_w;
              nxt_cur.cmd_count = cur_ff.cmd_count + 16'h0001;
              nxt_cur.param_idx = 4'h0;
              nxt_cur.busy_cnt = 16'h0000;
              nxt_cur.op_div = 1'b0;
              nxt_cur.params_left = {12'h000, dec_w.fixed_params};
              if (dec_w.kind == K_UNDEF) begin
                nxt_cur.undef_seen = 1'b1;
              end else if (dec_w.fixed_params == 4'h0) begin
                nxt_cur.phase = ST_EXEC;
              end else begin
                nxt_cur.phase = ST_PARAM;
              end
            end
            ST_PARAM: begin
              nxt_cur.param_idx = cur_ff.param_idx + 4'h1;
              // Coordinates stay raw two's complement words, so negative offsets need no extra handling.
              if (cur_ff.param_idx == 4'h0) nxt_cur.first_param = word_in;
              // Origin and pointer words: high word carries screen and upper address bits.
              if (cur_ff.dec.kind == K_ORG && cur_ff.param_idx == 4'h0) begin
                nxt_cur.pointer.screen_select_field = screen_t'(word_in[15:14]);
                nxt_cur.pointer.address[PTR_HIGH_BITS+PTR_LOW_BITS-1:PTR_LOW_BITS] = word_in[PTR_HIGH_BITS-1:0];
              end
              if (cur_ff.dec.kind == K_ORG && cur_ff.param_idx == 4'h1) begin
                nxt_cur.pointer.dot_in_word = word_in[15:PTR_LOW_BITS];
                nxt_cur.pointer.address[PTR_LOW_BITS-1:0] = word_in[PTR_LOW_BITS-1:0];
              end
              if (cur_ff.params_left == 16'h0001) begin
                if (cur_ff.dec.counted) begin
                  nxt_cur.phase = ST_COUNT;
                  nxt_cur.params_left = (cur_ff.dec.kind == K_WPTN) ? word_in : {word_in[14:0], 1'b0};
                end else begin
                  nxt_cur.phase = ST_EXEC;
                end
              end else begin
                nxt_cur.params_left = cur_ff.params_left - 16'h0001;
              end
            end
            ST_COUNT: begin
              nxt_cur.params_left = cur_ff.params_left - 16'h0001;
              if (cur_ff.params_left <= 16'h0001) nxt_cur.phase = ST_EXEC;
            end
            default: nxt_cur.phase = cur_ff.phase;
          endcase
          if (cur_ff.phase == ST_COUNT && cur_ff.params_left == 16'h0000) nxt_cur.phase = ST_EXEC;
        end
      end else if (PADDR_I == ADDR_CONTROL) begin
        nxt_cur.enable = PWDATA_I[0];
        nxt_cur.byte_mode = PWDATA_I[1];
        nxt_cur.high_pending = 1'b0;
        if (PWDATA_I[2]) nxt_cur.undef_seen = 1'b0;
      end else if (PADDR_I == ADDR_MASK) begin
        nxt_cur.mask = PWDATA_I[15:0];
      end else if (PADDR_I == ADDR_MOD_IN) begin
        nxt_cur.mod_in = PWDATA_I[15:0];
      end else if (PADDR_I == ADDR_STATUS || PADDR_I == ADDR_DECODE || PADDR_I == ADDR_OPINFO ||
                   PADDR_I == ADDR_POINTER || PADDR_I == ADDR_MOD_OUT || PADDR_I == ADDR_BYTE_WORD) begin
        nxt_cur.err = 1'b1;
      end else begin
        nxt_cur.err = 1'b1;
      end
    end
    // The modify result tracks the masked operation so software can check a word before store.
    if (cur_ff.dec.kind == K_MOD || cur_ff.dec.kind == K_SCLR || cur_ff.dec.kind == K_DMOD ||
        cur_ff.dec.kind == K_MASKED_AREA_COPY) begin
      nxt_cur.mod_out = mod_res;
    end
    // The set term needs word_valid, which a control write never has, so a clearing control write always clears the flag.
    if (wr_acc && PREADY_O && PADDR_I == ADDR_CONTROL && PWDATA_I[2] && word_valid) nxt_cur.undef_seen = 1'b1;
    nxt_cur.rdata = 32'h0000_0000;
    if (rd_acc) begin
      if (PADDR_I == ADDR_CONTROL) begin
        nxt_cur.rdata = {29'h0000_0000, 1'b0, cur_ff.byte_mode, cur_ff.enable};
      end else if (PADDR_I == ADDR_STATUS) begin
        nxt_cur.rdata = {cur_ff.cmd_count, 8'h00, 3'h0, cur_ff.high_pending, cur_ff.undef_seen,
                         (cur_ff.phase == ST_EXEC), 2'(cur_ff.phase)};
      end else if (PADDR_I == ADDR_DECODE) begin
        nxt_cur.rdata = {cur_ff.opcode, 2'h0, cur_ff.dec.group, cur_ff.dec.counted, cur_ff.dec.fixed_params,
                         7'(cur_ff.dec.kind)};
      end else if (PADDR_I == ADDR_OPINFO) begin
        nxt_cur.rdata = {7'h00, cur_ff.info};
      end else if (PADDR_I == ADDR_POINTER) begin
        nxt_cur.rdata = {6'h00, cur_ff.pointer};
      end else if (PADDR_I == ADDR_MASK) begin
        nxt_cur.rdata = {16'h0000, cur_ff.mask};
      end else if (PADDR_I == ADDR_MOD_IN) begin
        nxt_cur.rdata = {16'h0000, cur_ff.mod_in};
      end else if (PADDR_I == ADDR_MOD_OUT) begin
        nxt_cur.rdata = {16'h0000, cur_ff.mod_out};
      end else if (PADDR_I == ADDR_BYTE_WORD) begin
        nxt_cur.rdata = {16'h0000, cur_ff.first_param};
      end else begin
        nxt_cur.err = 1'b1;
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign PRDATA_O = nxt_cur.rdata;
  assign PSLVERR_O = PSEL_I && PENABLE_I && PREADY_O && nxt_cur.err;

endmodule : gcd_command_decoder

/* verification/gcd_chk.sv */
// Port checker for the command decoder bus side.
`timescale 1ns/1ps
module gcd_chk
  import gcd_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic PREADY_O,
  input wire logic PSLVERR_O
);
  // ==========================================================================
  // Bus assertions
  // ==========================================================================
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  wire logic acc = PSEL_I && PENABLE_I;

  a_stall_cmd_only: assert property (PSEL_I && !PREADY_O |-> PWRITE_I && PADDR_I == ADDR_CMD_WORD)
    else $error("stall outside a command write");
  a_stall_bounded: assert property (acc && !PREADY_O |-> ##[1:1000] PREADY_O)
    else $error("command stall too long");
  a_read_no_wait: assert property (acc && !PWRITE_I |-> PREADY_O)
    else $error("read was stalled");
  a_unmapped_err: assert property (acc && PADDR_I > ADDR_BYTE_WORD |-> PSLVERR_O)
    else $error("unmapped access not refused");
  a_status_ro: assert property (acc && PWRITE_I && PADDR_I == ADDR_STATUS |-> PSLVERR_O)
    else $error("status write not refused");
  a_decode_ro: assert property (acc && PWRITE_I && PADDR_I == ADDR_DECODE |-> PSLVERR_O)
    else $error("decode write not refused");
  a_mask_ok: assert property (acc && PADDR_I == ADDR_MASK |-> !PSLVERR_O)
    else $error("mask access refused");
  a_err_access_only: assert property (!acc |-> !PSLVERR_O)
    else $error("error outside access phase");
endmodule : gcd_chk

/* verification/host_model.sv */
// Host bus master that feeds command and parameter words.
`timescale 1ns/1ps
module host_model
  import gcd_pkg::*;
(
  input wire logic clk_i,
  output logic psel_o,
  output logic penable_o,
  output logic pwrite_o,
  output logic [11:0] paddr_o,
  output logic [31:0] pwdata_o,
  input wire logic [31:0] prdata_i,
  input wire logic pready_i,
  input wire logic pslverr_i
);
  logic [31:0] rdata;
  logic err;
  int waits;
  initial begin
    psel_o = 1'h0;
    penable_o = 1'h0;
    pwrite_o = 1'h0;
    paddr_o = 12'h000;
    pwdata_o = 32'h0;
  end
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel_o <= 1'h1;
    penable_o <= 1'h0;
    pwrite_o <= w;
    paddr_o <= a;
    pwdata_o <= d;
    @(posedge clk_i);
    penable_o <= 1'h1;
    waits = 0;
    @(posedge clk_i);
    while (pready_i !== 1'h1) begin
      waits++;
      @(posedge clk_i);
    end
    rdata = prdata_i;
    err = pslverr_i;
    psel_o <= 1'h0;
    penable_o <= 1'h0;
    // Released address and data lines flip so a stale value never passes for a live one.
    paddr_o <= ~a;
    pwdata_o <= ~d;
  endtask : xfer
  task automatic cmd(input logic [15:0] w);
    xfer(1'h1, ADDR_CMD_WORD, {16'h0, w});
  endtask : cmd
  function automatic logic [15:0] dph(input logic [1:0] s, input logic [7:0] hi);
    return {s, 6'h00, hi};
  endfunction : dph
  function automatic logic [15:0] dpl(input logic [3:0] dot, input logic [11:0] lo);
    return {dot, lo};
  endfunction : dpl
endmodule : host_model

/* verification/testbench.sv */
// Self-checking bench for the command decoder.
`timescale 1ns/1ps
module testbench
  import gcd_pkg::*;
();
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [15:0] op;
  logic [15:0] mexp [4] = '{16'h3A3A, 16'h3E3E, 16'h3838, 16'h3636};
  int failures = 0;
  int comparisons = 0;
  int w0;
  // Index of the frame_access_pointer parameter register; the value is arbitrary.
  localparam logic [4:0] FAP_REG_INDEX = 5'h0C;
  always #20 clk = ~clk;
  gcd_command_decoder uut (.CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr));
  host_model u_host (.clk_i(clk), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
    .paddr_o(paddr), .pwdata_o(pwdata), .prdata_i(prdata), .pready_i(pready), .pslverr_i(pslverr));
  // ==========================================================================
  // Checking and closing
  // ==========================================================================
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] exp);
    u_host.xfer(1'h0, a, 32'h0);
    chk(u_host.rdata & m, exp);
  endtask : rd
  task automatic wait_idle();
    for (int i = 0; i < 200; i++) begin
      u_host.xfer(1'h0, ADDR_STATUS, 32'h0);
      if (u_host.rdata[2] === 1'h0) break;
    end
    if (u_host.rdata[2] !== 1'h0) begin
      failures++;
      $display("[ERR] %0t idle wait ran out", $time);
    end
  endtask : wait_idle
  task automatic give_verdict();
    $display("failures=%0d comparisons=%0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : give_verdict
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    give_verdict();
  end
  // ==========================================================================
  // Scenarios
  // ==========================================================================
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'h1;
    rd(ADDR_CONTROL, 32'hFFFFFFFF, 32'h0);
    rd(ADDR_STATUS, 32'hFFFFFFFF, 32'h0);
    u_host.cmd(16'hFFFF);
    rd(ADDR_STATUS, 32'h8, 32'h0);
    u_host.xfer(1'h1, ADDR_CONTROL, 32'h1);
    u_host.cmd(16'hFFFF);
    rd(ADDR_STATUS, 32'h8, 32'h8);
    u_host.xfer(1'h1, ADDR_CONTROL, 32'h5);
    rd(ADDR_STATUS, 32'h8, 32'h0);
    u_host.xfer(1'h1, ADDR_STATUS, 32'h0);
    chk({31'h0, u_host.err}, 32'h1);
    u_host.xfer(1'h1, ADDR_DECODE, 32'h0);
    chk({31'h0, u_host.err}, 32'h1);
    u_host.xfer(1'h0, 12'h030, 32'h0);
    chk({31'h0, u_host.err}, 32'h1);
    u_host.cmd(16'h0800 | 16'(FAP_REG_INDEX));
    u_host.cmd(16'h0000);
    // The stall of a following read command differs only by the dot cost.
    for (int k = 0; k < 2; k++) begin
      op = k ? 16'hCCB4 : 16'hCCB3;
      u_host.cmd(op);
      rd(ADDR_OPINFO, 32'h01FFE000, {7'h0, 3'h5, 2'h2, op[2:0], k ? DOT_COST_COND : DOT_COST_SIMPLE, 13'h0});
      rd(ADDR_DECODE, 32'h3FFF, {18'h0, GRP_DRAW, 1'h0, 4'h0, 1'h0, K_DOT});
      u_host.cmd(16'h4400);
      if (k == 0) w0 = u_host.waits;
    end
    chk(32'(u_host.waits - w0), 32'h4);
    wait_idle();
    for (int s = 0; s < 4; s++) begin
      u_host.cmd(16'h0400);
      u_host.cmd(u_host.dph(s[1:0], 8'hA5 ^ 8'(s)));
      u_host.cmd(u_host.dpl(4'h9, 12'h3C6));
      wait_idle();
      rd(ADDR_POINTER, 32'h03FFFFFF, {6'h0, s[1:0], 4'h9, 8'hA5 ^ 8'(s), 12'h3C6});
    end
    u_host.cmd(16'h0813);
    rd(ADDR_OPINFO, 32'h1F0, 32'h130);
    u_host.cmd(16'h0001);
    u_host.cmd(16'h180F);
    rd(ADDR_OPINFO, 32'hF, 32'hF);
    u_host.cmd(16'h0001);
    u_host.cmd(16'h1234);
    wait_idle();
    u_host.xfer(1'h1, ADDR_MASK, 32'h0F0F);
    u_host.xfer(1'h1, ADDR_MOD_IN, 32'h3C3C);
    rd(ADDR_MASK, 32'hFFFF, 32'h0F0F);
    for (int m = 0; m < 4; m++) begin
      u_host.cmd(16'h4C00 | 16'(m));
      u_host.cmd(16'h5A5A);
      wait_idle();
      rd(ADDR_MOD_OUT, 32'hFFFF, {16'h0, mexp[m]});
    end
    u_host.cmd(16'h8800);
    u_host.cmd(16'hFFF6);
    u_host.cmd(16'h000A);
    wait_idle();
    rd(ADDR_BYTE_WORD, 32'hFFFFFFFF, 32'h0000FFF6);
    u_host.cmd(16'h7003);
    repeat (4) u_host.cmd(16'h0000);
    wait_idle();
    rd(ADDR_DECODE, 32'h3FFF, {18'h0, GRP_XFER, 1'h0, 4'h4, 1'h0, K_MASKED_AREA_COPY});
    rd(ADDR_MOD_OUT, 32'hFFFF, 32'h3C3C);
    u_host.xfer(1'h1, ADDR_CONTROL, 32'h3);
    u_host.xfer(1'h1, ADDR_CMD_WORD, 32'h44);
    rd(ADDR_STATUS, 32'h10, 32'h10);
    u_host.xfer(1'h1, ADDR_CMD_WORD, 32'h00);
    rd(ADDR_DECODE, 32'h3FFF, {18'h0, GRP_XFER, 1'h0, 4'h0, 1'h0, K_RD});
    wait_idle();
    give_verdict();
  end
endmodule : testbench

bind gcd_command_decoder gcd_chk u_chk (.CLK_I(testbench.clk), .RST_N_I(testbench.rst_n),
  .PSEL_I(testbench.psel), .PENABLE_I(testbench.penable), .PWRITE_I(testbench.pwrite),
  .PADDR_I(testbench.paddr), .PWDATA_I(testbench.pwdata), .PRDATA_O(testbench.prdata),
  .PREADY_O(testbench.pready), .PSLVERR_O(testbench.pslverr));
